// [dv/lcd_drive_ctrl_assertions.sv]
// Purpose: Port checks for lcd_drive_ctrl
// Assumes: One clock, bound to the top module
// Notes:   Line-level holds are left to the bench; on/off is not visible here
`timescale 1ns/10ps
module lcd_drive_ctrl_assertions
  import lcd_pkg::*;
#(
  parameter int unsigned SEG_N       = 61,
  parameter int unsigned COM_N       = 16,
  parameter int unsigned LINE_CYCLES = 128
)
(
  input wire logic                   i_ref_clk,
  input wire logic                   i_resetn,
  input wire lcd_apb_req_t           i_apb,
  input wire lcd_apb_rsp_t           o_apb,
  input wire lcd_level_t [SEG_N-1:0] o_segment_outputs,
  input wire lcd_level_t [COM_N-1:0] o_common_outputs,
  input wire logic                   o_frame_polarity
);
  logic [6:0] up_cnt;

  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);

  // Saturates so the busy window is judged once per release
  always_ff @(posedge i_ref_clk or negedge i_resetn)
    if (!i_resetn)
      up_cnt <= 7'h00;
    else if (up_cnt != 7'h7f)
      up_cnt <= up_cnt + 7'h01;

  sequence s_setup;
    i_apb.psel && !i_apb.penable;
  endsequence
  sequence s_access;
    i_apb.psel && i_apb.penable;
  endsequence

  a_busy_all_vdd: assert property (up_cnt <= RESET_CYCLES |-> o_segment_outputs == '0 && o_common_outputs == '0)
    else $error("drive not at VDD during reset");
  a_reset_done: assert property (up_cnt == RESET_CYCLES |-> ##[1:2] o_segment_outputs[0] == LVL_V3)
    else $error("reset not complete in time");
  a_apb_wait: assert property (s_setup ##1 s_access |-> !o_apb.pready ##1 o_apb.pready)
    else $error("ready not one wait state");
  a_ready_pulse: assert property (o_apb.pready |=> !o_apb.pready)
    else $error("ready longer than one cycle");
  a_ready_cause: assert property (o_apb.pready |-> i_apb.psel && i_apb.penable && $past(i_apb.penable))
    else $error("ready without access");
  a_bad_addr: assert property (o_apb.pready |-> o_apb.pslverr == (i_apb.paddr > OFS_STATUS)
                               && (!o_apb.pslverr || o_apb.prdata == '0))
    else $error("error response wrong");
  a_seg_legal: assert property (o_segment_outputs[0] inside {LVL_VDD, LVL_V2, LVL_V3, LVL_V5})
    else $error("segment level illegal");
  a_com_legal: assert property (o_common_outputs[0] inside {LVL_VDD, LVL_V1, LVL_V4, LVL_V5})
    else $error("common level illegal");
  a_frame_hold: assert property ($changed(o_frame_polarity) |=> $stable(o_frame_polarity) [*8])
    else $error("frame toggled too soon");
endmodule

bind lcd_drive_ctrl lcd_drive_ctrl_assertions #(.SEG_N(SEG_N), .COM_N(COM_N), .LINE_CYCLES(LINE_CYCLES))
  lcd_drive_ctrl_assertions_i (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_apb(i_apb), .o_apb(o_apb),
  .o_segment_outputs(o_segment_outputs), .o_common_outputs(o_common_outputs), .o_frame_polarity(o_frame_polarity));

// [dv/lcd_drive_ctrl_test.sv]
// Purpose: Self-checking bench for lcd_drive_ctrl
// Assumes: Panel and line shortened; host model drives the bus
// Notes:   Register model is an int array indexed by word offset
`timescale 1ns/10ps
module lcd_drive_ctrl_test import lcd_pkg::*;;
  localparam int unsigned SN = 4;
  localparam int unsigned CN = 4;
  localparam int unsigned LC = SN + 2;
  logic                i_ref_clk;
  logic                i_resetn;
  lcd_apb_req_t        apb_req;
  lcd_apb_rsp_t        apb_rsp;
  lcd_level_t [SN-1:0] segment_lvl;
  lcd_level_t [CN-1:0] common_lvl;
  lcd_level_t [CN-1:0] snap;
  logic                frame;
  logic [31:0]         rd;
  logic                err;
  int                  mismatches;
  int                  n_compared;
  int                  m_reg [8];
  int                  k;
  int                  sel;
  logic [7:0]          codes [3] = '{8'he0, 8'hee, 8'he2};

`define CHK(nm, ex, got) \
  begin \
    n_compared++; \
    if ((got) !== (ex)) \
    begin \
      mismatches++; \
      $display("unexpected %s: expected %0h seen %0h", nm, (ex), (got)); \
    end \
  end

  lcd_drive_ctrl #(.SEG_N(SN), .COM_N(CN), .LINE_CYCLES(LC)) lcd_drive_ctrl_i (.i_ref_clk(i_ref_clk),
    .i_resetn(i_resetn), .i_apb(apb_req), .o_apb(apb_rsp), .o_segment_outputs(segment_lvl),
    .o_common_outputs(common_lvl), .o_frame_polarity(frame));
  lcd_host_model lcd_host_model_i (.i_ref_clk(i_ref_clk), .i_apb(apb_rsp), .o_apb(apb_req));

  initial
  begin
    i_ref_clk = 1'b0;
    forever #12.5 i_ref_clk = ~i_ref_clk;
  end

  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    lcd_host_model_i.xfer(w, a, d, rd, err);
    `CHK("pslverr", a > OFS_STATUS, err)
  endtask

  task automatic wreg(input logic [7:0] a, input int v);
    acc(1'b1, a, v);
    m_reg[a >> 2] = v;
  endtask

  task automatic rchk(input logic [7:0] a, input int ex);
    acc(1'b0, a, 0);
    `CHK("read data", ex, rd)
  endtask

  initial
  begin
    repeat (5000) @(posedge i_ref_clk);
    mismatches++;
    results();
  end

  initial
  begin
    i_resetn = 1'b0;
    mismatches = 0;
    n_compared = 0;
    m_reg = '{default: 0};
    void'($urandom(66289));
    repeat (20) @(posedge i_ref_clk);
    i_resetn <= 1'b1;
    acc(1'b0, OFS_STATUS, 0);
    `CHK("busy", 1'b1, rd[ST_BUSY_BIT])
    acc(1'b1, OFS_START_LINE, 5);
    k = 0;
    do
    begin
      acc(1'b0, OFS_STATUS, 0);
      k++;
    end
    while (rd[ST_BUSY_BIT] !== 1'b0 && k < 20);
    `CHK("status", 32'h2, rd & 32'h3)
    for (k = 2; k < 6; k++)
      rchk(8'(k * 4), m_reg[k]);
    acc(1'b0, 8'h40, 0);
    `CHK("unmapped data", 32'h0, rd)
    $display("test reset done");
    wreg(OFS_START_LINE, $urandom_range(31, 1));
    wreg(OFS_COLUMN, $urandom_range(79));
    for (int c = 0; c < 3; c++)
    begin
      wreg(OFS_PAGE, $urandom_range(2));
      acc(1'b1, OFS_CMD, {24'h0, codes[c]});
      if (codes[c] == CMD_SOFT_RESET)
      begin
        m_reg[2] = 0;
        m_reg[3] = 3;
      end
      for (k = 2; k < 6; k++)
        rchk(8'(k * 4), m_reg[k]);
    end
    $display("test command done");
    wreg(OFS_PAGE, 0);
    wreg(OFS_COLUMN, 0);
    acc(1'b1, OFS_DATA, 32'hff);
    m_reg[4] = 1;
    wreg(OFS_DISP_ON, 1);
    acc(1'b1, OFS_CMD, {24'h0, CMD_SOFT_RESET});
    m_reg[2] = 0;
    m_reg[3] = 3;
    rchk(OFS_PAGE, m_reg[3]);
    rchk(OFS_COLUMN, m_reg[4]);
    rchk(OFS_DISP_ON, 1);
    repeat (2 * LC) @(negedge i_ref_clk);
    for (k = 0; k < 10; k++)
    begin
      repeat (5) @(negedge i_ref_clk);
      sel = 0;
      foreach (common_lvl[j])
        sel += int'(common_lvl[j] == LVL_VDD || common_lvl[j] == LVL_V5);
      `CHK("pixel on", 1'b1, segment_lvl[0] inside {LVL_V5, LVL_VDD})
      `CHK("pixel off", 1'b1, segment_lvl[1] inside {LVL_V3, LVL_V2})
      `CHK("selected rows", 1, sel)
    end
    wreg(OFS_DISP_ON, 0);
    repeat (2 * LC) @(negedge i_ref_clk);
    snap = common_lvl;
    for (k = 0; k < 8; k++)
    begin
      repeat (5) @(negedge i_ref_clk);
      `CHK("off segment", 1'b1, segment_lvl[0] inside {LVL_V2, LVL_V3})
      `CHK("held common", snap, common_lvl)
    end
    sel = int'(frame);
    while (int'(frame) == sel)
      @(negedge i_ref_clk);
    sel = int'(frame);
    k = 0;
    while (int'(frame) == sel)
    begin
      @(negedge i_ref_clk);
      k++;
    end
    `CHK("frame period", CN * LC, k)
    $display("test display done");
    results();
  end
endmodule

// [dv/lcd_host_model.sv]
// Purpose: Host side APB master for the drive block
// Assumes: Requests start just after a rising edge
// Notes:   Released lines carry inverted values so stale data is not trusted
`timescale 1ns/10ps
module lcd_host_model
  import lcd_pkg::*;
(
  input  wire logic   i_ref_clk,
  input  wire lcd_apb_rsp_t i_apb,
  output lcd_apb_req_t      o_apb
);
  initial o_apb = '0;

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    @(posedge i_ref_clk);
    o_apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge i_ref_clk);
    o_apb.penable <= 1'b1;
    // Waits without limit; only the bench watchdog ends a hung transfer
    do
    begin
      @(posedge i_ref_clk);
    end
    while (i_apb.pready !== 1'b1);
    rd = i_apb.prdata;
    err = i_apb.pslverr;
    o_apb <= '{psel: 1'b0, penable: 1'b0, pwrite: ~w, paddr: ~a, pwdata: ~d};
  endtask
endmodule

// [include/lcd_pkg.sv]
// Purpose: Shared types and constants of the LCD drive-select and command block
// Assumes: 40 MHz reference clock, APB register access with 32-bit data
// Notes:   Drive levels are codes; the analog switch matrix turns them into voltages
package lcd_pkg;

  localparam int unsigned APB_AW = 8;

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [APB_AW-1:0] paddr;
    logic [31:0]       pwdata;
  } lcd_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } lcd_apb_rsp_t;

  // Drive level codes for segment and common outputs
  typedef enum logic [2:0] {
    LVL_VDD = 3'b000,
    LVL_V1  = 3'b001,
    LVL_V2  = 3'b010,
    LVL_V3  = 3'b011,
    LVL_V4  = 3'b100,
    LVL_V5  = 3'b101
  } lcd_level_t;

  // Register byte offsets
  localparam logic [APB_AW-1:0] OFS_CMD        = 8'h00;
  localparam logic [APB_AW-1:0] OFS_DATA       = 8'h04;
  localparam logic [APB_AW-1:0] OFS_START_LINE = 8'h08;
  localparam logic [APB_AW-1:0] OFS_PAGE       = 8'h0c;
  localparam logic [APB_AW-1:0] OFS_COLUMN     = 8'h10;
  localparam logic [APB_AW-1:0] OFS_DISP_ON    = 8'h14;
  localparam logic [APB_AW-1:0] OFS_STATUS     = 8'h18;

  // Field widths and positions
  localparam int unsigned START_W       = 5;
  localparam int unsigned PAGE_W        = 2;
  localparam int unsigned COL_W         = 7;
  localparam int unsigned ST_BUSY_BIT   = 0;
  localparam int unsigned ST_OFF_BIT    = 1;
  localparam int unsigned ST_FRAME_BIT  = 2;
  localparam int unsigned ST_COM_LSB    = 4;
  localparam int unsigned ST_COM_W      = 4;

  // Command codes
  localparam logic [7:0] CMD_SOFT_RESET = 8'he2;

  // Values after hardware reset
  localparam logic [START_W-1:0] START_LINE_RST = 5'h00;
  localparam logic [PAGE_W-1:0]  PAGE_RST       = 2'h0;
  localparam logic [COL_W-1:0]   COLUMN_RST     = 7'h00;
  localparam logic               DISP_ON_RST    = 1'b0;

  // Values loaded by the software reset command
  localparam logic [START_W-1:0] SOFT_START_LINE = 5'h00;
  localparam logic [PAGE_W-1:0]  SOFT_PAGE       = 2'h3;

  // Display memory geometry
  localparam int unsigned MEM_COLS  = 80;
  localparam int unsigned MEM_PAGES = 4;
  localparam int unsigned MEM_DEPTH = MEM_COLS * MEM_PAGES;
  localparam int unsigned MEM_AW    = 9;

  // Timing
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam real         RESET_TIME_US = 1.0;
  localparam int unsigned RESET_CYCLES  = int'(RESET_TIME_US * 1000.0) / CLK_PERIOD_NS;

endpackage

// [rtl/lcd_dmem.sv]
// Purpose: Display data memory, one write port and one registered read port
// Assumes: Single clock, writes and reads may fall in the same cycle
// Notes:   Read data appears one cycle after the read address
`timescale 1ns/10ps
module lcd_dmem
  import lcd_pkg::*;
#(
  parameter int unsigned W     = 8,
  parameter int unsigned DEPTH = MEM_DEPTH,
  parameter int unsigned AW    = MEM_AW
)
(
  input  wire logic          i_ref_clk,
  input  wire logic          i_resetn,
  input  wire logic          i_wr_en,
  input  wire logic [AW-1:0] i_wr_addr,
  input  wire logic [W-1:0]  i_wr_data,
  input  wire logic          i_rd_en,
  input  wire logic [AW-1:0] i_rd_addr,
  output logic      [W-1:0]  o_rd_data
);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [W-1:0]            rdata;
  } dmem_state_t;

  dmem_state_t s;
  dmem_state_t next_s;

  if ((DEPTH < 1) || (AW < $clog2(DEPTH)))
  begin : g_param_check
    $error("lcd_dmem: address too narrow for depth");
  end

  always_comb
  begin
    next_s = s;
    if (i_wr_en && (int'(i_wr_addr) < DEPTH))
    begin
      next_s.mem[i_wr_addr] = i_wr_data;
    end
    if (i_rd_en && (int'(i_rd_addr) < DEPTH))
    begin
      next_s.rdata = s.mem[i_rd_addr];
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign o_rd_data = s.rdata;

endmodule

// [rtl/lcd_drive_ctrl.sv]
// Purpose: Software reset command and segment/common drive level selection
// Assumes: One 40 MHz clock times control, pixel rate and frame; APB registers
// Notes:   Drive levels are codes; the busy window after reset lasts 1.0 us
// Operation
// - Software reset clears the five-bit start line register to zero.
// - Software reset loads the two-bit page address register with three.
// - Software reset leaves display memory and all other registers untouched.
// - Command code e2 written with command select low decodes as software reset.
// - Segment level from frame and pixel when on; V2 or V3 when off.
// - Common level from frame and row select when on; holds level when off.
// - Row select comes from an internal common counter stepping through the rows.
// - During reset every segment and common output drives the VDD level.
// - One internal clock times control logic, pixel rate and frame signal.
// - Hardware reset completes no later than 1.0 us after reset release.
//
// Implementation choices: the address map and register access over APB.
`timescale 1ns/10ps
module lcd_drive_ctrl
  import lcd_pkg::*;
#(
  parameter int unsigned SEG_N       = 61,
  parameter int unsigned COM_N       = 16,
  parameter int unsigned LINE_CYCLES = 128
)
(
  input  wire logic                        i_ref_clk,
  input  wire logic                        i_resetn,
  input  wire lcd_apb_req_t                i_apb,
  output lcd_apb_rsp_t                     o_apb,
  output lcd_level_t   [SEG_N-1:0]         o_segment_outputs,
  output lcd_level_t   [COM_N-1:0]         o_common_outputs,
  output logic                             o_frame_polarity
);

  localparam int unsigned LCW = $clog2(LINE_CYCLES);
  localparam int unsigned CW  = $clog2(COM_N);

  // The scan needs one cycle per column plus the read latency within each line
  if ((LINE_CYCLES < SEG_N + 2) || (SEG_N > MEM_COLS) || (SEG_N < 1)
      || (COM_N < 2) || (COM_N > (1 << ST_COM_W)) || (COM_N > 32))
  begin : g_param_check
    $error("lcd_drive_ctrl: unsupported parameter set");
  end

  // The busy counter is six bits wide; a longer reset window would never end
  if ((RESET_CYCLES < 1) || (RESET_CYCLES > 64))
  begin : g_reset_check
    $error("lcd_drive_ctrl: reset window does not fit the busy counter");
  end

  typedef struct packed {
    logic                   busy;
    logic [5:0]             busy_cnt;
    logic [START_W-1:0]     start_line;
    logic [PAGE_W-1:0]      page;
    logic [COL_W-1:0]       column;
    logic                   disp_on;
    logic [LCW-1:0]         line_cnt;
    logic [CW-1:0]          com_cnt;
    logic                   frame;
    logic [SEG_N-1:0]       fetch_buf;
    logic [SEG_N-1:0]       pix;
    lcd_level_t [SEG_N-1:0] seg;
    lcd_level_t [COM_N-1:0] com;
    logic                   mem_we;
    logic [MEM_AW-1:0]      mem_waddr;
    logic [7:0]             mem_wdata;
    lcd_apb_rsp_t           apb;
  } ctrl_state_t;

  localparam ctrl_state_t STATE_RST = '{
    busy:       1'b1,
    busy_cnt:   6'h00,
    start_line: START_LINE_RST,
    page:       PAGE_RST,
    column:     COLUMN_RST,
    disp_on:    DISP_ON_RST,
    line_cnt:   '0,
    com_cnt:    '0,
    frame:      1'b0,
    fetch_buf:  '0,
    pix:        '0,
    seg:        '{default: LVL_VDD},
    com:        '{default: LVL_VDD},
    mem_we:     1'b0,
    mem_waddr:  '0,
    mem_wdata:  8'h00,
    apb:        '0
  };

  ctrl_state_t s;
  ctrl_state_t next_s;

  logic              rd_en;
  logic [MEM_AW-1:0] rd_addr;
  logic [7:0]        rd_data;
  logic [CW-1:0]     com_next;
  logic [4:0]        fetch_row;
  logic              apb_done;

  function automatic logic [MEM_AW-1:0] mem_addr(input logic [PAGE_W-1:0] page,
                                                 input logic [COL_W-1:0]  col);
    mem_addr = MEM_AW'(int'(page) * MEM_COLS + int'(col));
  endfunction

  function automatic lcd_level_t seg_level(input logic frame, input logic pixel, input logic on);
    if (!on)
    begin
      seg_level = frame ? LVL_V2 : LVL_V3;
    end
    else if (!frame)
    begin
      seg_level = pixel ? LVL_V5 : LVL_V3;
    end
    else
    begin
      seg_level = pixel ? LVL_VDD : LVL_V2;
    end
  endfunction

  function automatic lcd_level_t com_level(input logic frame, input logic selected);
    if (!frame)
    begin
      com_level = selected ? LVL_VDD : LVL_V4;
    end
    else
    begin
      com_level = selected ? LVL_V5 : LVL_V1;
    end
  endfunction

  lcd_dmem #(
    .W     (8),
    .DEPTH (MEM_DEPTH),
    .AW    (MEM_AW)
  ) u_dmem (
    .i_ref_clk (i_ref_clk),
    .i_resetn  (i_resetn),
    .i_wr_en   (s.mem_we),
    .i_wr_addr (s.mem_waddr),
    .i_wr_data (s.mem_wdata),
    .i_rd_en   (rd_en),
    .i_rd_addr (rd_addr),
    .o_rd_data (rd_data)
  );

  // Row that the next line shows; the data memory is fetched one line ahead
  always_comb
  begin
    if (int'(s.com_cnt) == COM_N - 1)
    begin
      com_next = '0;
    end
    else
    begin
      com_next = CW'(int'(s.com_cnt) + 1);
    end
    fetch_row = 5'(int'(s.start_line) + int'(com_next));
    // Reads are only issued for columns that reach a segment
    rd_en     = !s.busy && (int'(s.line_cnt) < SEG_N);
    rd_addr   = mem_addr(fetch_row[4:3], COL_W'(s.line_cnt));
    apb_done  = i_apb.psel && i_apb.penable && s.apb.pready;
  end

  always_comb
  begin
    next_s = s;
    next_s.mem_we = 1'b0;

    // Hardware reset sequence: counted from release, done within the limit
    if (s.busy)
    begin
      if (int'(s.busy_cnt) >= RESET_CYCLES - 1)
      begin
        next_s.busy = 1'b0;
      end
      else
      begin
        next_s.busy_cnt = 6'(int'(s.busy_cnt) + 1);
      end
    end

    // APB slave: one wait state, answer registered
    next_s.apb.pready = 1'b0;
    if (i_apb.psel && i_apb.penable && !s.apb.pready)
    begin
      next_s.apb.pready  = 1'b1;
      next_s.apb.pslverr = 1'b0;
      next_s.apb.prdata  = 32'h0000_0000;
      if (i_apb.paddr == OFS_CMD)
      begin
        next_s.apb.prdata = 32'h0000_0000;
      end
      else if (i_apb.paddr == OFS_DATA)
      begin
        next_s.apb.prdata = 32'h0000_0000;
      end
      else if (i_apb.paddr == OFS_START_LINE)
      begin
        next_s.apb.prdata[START_W-1:0] = s.start_line;
      end
      else if (i_apb.paddr == OFS_PAGE)
      begin
        next_s.apb.prdata[PAGE_W-1:0] = s.page;
      end
      else if (i_apb.paddr == OFS_COLUMN)
      begin
        next_s.apb.prdata[COL_W-1:0] = s.column;
      end
      else if (i_apb.paddr == OFS_DISP_ON)
      begin
        next_s.apb.prdata[0] = s.disp_on;
      end
      else if (i_apb.paddr == OFS_STATUS)
      begin
        next_s.apb.prdata[ST_BUSY_BIT]                      = s.busy;
        next_s.apb.prdata[ST_OFF_BIT]                       = !s.disp_on;
        next_s.apb.prdata[ST_FRAME_BIT]                     = s.frame;
        next_s.apb.prdata[ST_COM_LSB +: ST_COM_W]           = ST_COM_W'(s.com_cnt);
      end
      else
      begin
        // Unmapped offsets answer with an error and change nothing
        next_s.apb.pslverr = 1'b1;
      end
    end

    // Writes land at the edge where pready is sampled; ignored while busy
    if (apb_done && i_apb.pwrite && !s.busy)
    begin
      if (i_apb.paddr == OFS_CMD)
      begin
        if (i_apb.pwdata[7:0] == CMD_SOFT_RESET)
        begin
          // Only these two registers move; memory and the rest stay as they are
          next_s.start_line = SOFT_START_LINE;
          next_s.page       = SOFT_PAGE;
        end
      end
      else if (i_apb.paddr == OFS_DATA)
      begin
        next_s.mem_we    = 1'b1;
        next_s.mem_waddr = mem_addr(s.page, s.column);
        next_s.mem_wdata = i_apb.pwdata[7:0];
        // Column stops at the last column rather than wrapping into the next page
        if (int'(s.column) < MEM_COLS - 1)
        begin
          next_s.column = COL_W'(int'(s.column) + 1);
        end
      end
      else if (i_apb.paddr == OFS_START_LINE)
      begin
        next_s.start_line = i_apb.pwdata[START_W-1:0];
      end
      else if (i_apb.paddr == OFS_PAGE)
      begin
        next_s.page = i_apb.pwdata[PAGE_W-1:0];
      end
      else if (i_apb.paddr == OFS_COLUMN)
      begin
        if (int'(i_apb.pwdata[COL_W-1:0]) < MEM_COLS)
        begin
          next_s.column = i_apb.pwdata[COL_W-1:0];
        end
      end
      else if (i_apb.paddr == OFS_DISP_ON)
      begin
        next_s.disp_on = i_apb.pwdata[0];
      end
    end

    // Raster scan, frame and pixel timing all run on the one reference clock
    if (!s.busy)
    begin
      if (int'(s.line_cnt) >= 1 && int'(s.line_cnt) <= SEG_N)
      begin
        next_s.fetch_buf[int'(s.line_cnt) - 1] = rd_data[fetch_row[2:0]];
      end
      if (int'(s.line_cnt) == LINE_CYCLES - 1)
      begin
        next_s.line_cnt = '0;
        next_s.com_cnt  = com_next;
        next_s.pix      = s.fetch_buf;
        if (com_next == '0)
        begin
          next_s.frame = !s.frame;
        end
      end
      else
      begin
        next_s.line_cnt = LCW'(int'(s.line_cnt) + 1);
      end
    end

    // Output levels; during the reset sequence all stay at VDD
    for (int i = 0; i < SEG_N; i++)
    begin
      if (s.busy)
      begin
        next_s.seg[i] = LVL_VDD;
      end
      else
      begin
        next_s.seg[i] = seg_level(s.frame, s.pix[i], s.disp_on);
      end
    end
    // Off: commons keep their last level while segments park at V2 or V3
    for (int k = 0; k < COM_N; k++)
    begin
      if (s.busy)
      begin
        next_s.com[k] = LVL_VDD;
      end
      else if (s.disp_on)
      begin
        next_s.com[k] = com_level(s.frame, int'(s.com_cnt) == k);
      end
      else
      begin
        next_s.com[k] = s.com[k];
      end
    end
  end

  // Asynchronous reset puts every segment and common output at VDD at once
  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      s <= STATE_RST;
    end
    else
    begin
      s <= next_s;
    end
  end

  // Every output comes straight from the state register
  assign o_apb             = s.apb;
  assign o_segment_outputs = s.seg;
  assign o_common_outputs  = s.com;
  assign o_frame_polarity  = s.frame;

endmodule
